// >>> cpem_regs.svh
// Purpose: Register offsets, field codes, reset values and timing counts
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Definitions only
`ifndef CPEM_REGS_SVH
`define CPEM_REGS_SVH
`define CPEM_A_CAP 8'h08
`define CPEM_A_OVR 8'h09
`define CPEM_A_PCLK 8'h0d
`define CPEM_A_EOMC 8'h11
`define CPEM_A_SIGD 8'h14
`define CPEM_A_DIV 8'h18
`define CPEM_A_CPMP 8'h1b
`define CPEM_A_OMUX 8'h1e
`define CPEM_A_VCTL 8'h1f
`define CPEM_A_HITM 8'h25
`define CPEM_A_HITL 8'h26
`define CPEM_A_HOPN 8'h27
`define CPEM_A_VOPN 8'h28
`define CPEM_A_ITVL 8'h2a
`define CPEM_A_PSEL 8'h30
`define CPEM_A_STAT 8'h31
`define CPEM_EOMC_RST 8'h20
`define CPEM_OMUX_RST 8'he0
`define CPEM_CAP_RST 8'h08
`define CPEM_VCTL_RST 8'h12
`define CPEM_CPMP_RST 8'h03
`define CPEM_ITVL_RST 8'h10
`define CPEM_SEL_PRBS 3'h4
`define CPEM_SEL_ICLK 3'h2
`define CPEM_SEL_MUTE 3'h7
`define CPEM_PAT_P9 2'h0
`define CPEM_PAT_P31 2'h2
`define CPEM_MEAS_PERIOD_US 10
`define CPEM_CLK_MHZ 200
`define CPEM_MEAS_CYC (`CPEM_MEAS_PERIOD_US * `CPEM_CLK_MHZ)
`define CPEM_SWEEP_LAST 6'h3f
`define CPEM_MID_VOLT 6'h20
`endif

// >>> cpem_pkg.sv
// Purpose: Types for the channel pattern and eye monitor block
// Assumes: Constants live in cpem_regs.svh
// Notes: One-hot eye measurement states
package cpem_pkg;
  typedef enum logic [3:0] {
    CPEM_IDLE = 4'b0001,
    CPEM_HSWP = 4'b0010,
    CPEM_VSWP = 4'b0100,
    CPEM_DONE = 4'b1000
  } cpem_state_t;
endpackage : cpem_pkg

// >>> cpem_top.sv
// Purpose: Channel pattern generator, free-run overrides and eye monitor control
// Assumes: I_CLK is the channel VCO clock; comparator decisions arrive asynchronously
// Notes: Read data valid one cycle after the read strobe
// Operation
// RULE1: Generator makes 9-stage or 31-stage sequence
// RULE2: Sync mode keeps VCO locked regardless mux
// RULE3: Controller enables, unloads, selects, loads, clocks
// RULE4: Select 0x0 short, 0x2 long sequence
// RULE5: Override plus select 0x4 drives pattern
// RULE6: No signal powers channel and driver down
// RULE7: Upper set, lower clear forces signal detect
// RULE8: Bit3 plus zero field stops charge pump
// RULE9: Bit2 hands divider to field, zero divides one
// RULE10: Bit7 takes capacitor count from field
// RULE11: Bit6 enables control voltage source from field
// RULE12: Controller keeps earlier override bits set
// RULE13: Override register resets zero, zero restores normal
// RULE14: Controller measures in-phase clock, then reselects pattern
// RULE15: Hit when offset decision differs from primary
// RULE16: Sweep phase at mid voltage, then voltage
// RULE17: Latest openings held as single bytes
// RULE18: Recovery periodically measures both openings
// RULE19: Monitor power-down resets one, cleared externally
// RULE20: Range bits share register with power-down
// RULE21: Range codes map 100 to 400 millivolts
// RULE22: Customary polynomials, never all-zero state
`timescale 1ns/1ps
`include "cpem_regs.svh"
module cpem_top
  import cpem_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_SIG_PRESENT,
  input wire logic I_CDR_LOCKED,
  input wire logic I_PRIMARY_BIT,
  input wire logic I_OFFSET_BIT,
  input wire logic I_RETIMED_BIT,
  input wire logic I_RAW_BIT,
  input wire logic I_ICLK_BIT,
  output logic O_TX_BIT,
  output logic O_CH_ENABLE,
  output logic O_CHARGE_PUMP_EN,
  output logic [2:0] O_DIV_SEL,
  output logic O_DIV_OVR,
  output logic [4:0] O_CAP_COUNT,
  output logic O_CAP_OVR,
  output logic O_VCTL_EN,
  output logic [4:0] O_VCTL_CODE,
  output logic O_PLL_FREE_RUN,
  output logic O_EOM_POWER,
  output logic [8:0] O_EOM_RANGE_MV,
  output logic [5:0] O_EOM_PHASE,
  output logic [5:0] O_EOM_VOLT
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {I_SIG_PRESENT, I_CDR_LOCKED, I_PRIMARY_BIT, I_OFFSET_BIT,
                  I_RETIMED_BIT, I_RAW_BIT, I_ICLK_BIT};
      sync2_q <= sync1_q;
    end
  end
  logic sig_s, lock_s, prim_s, offs_s, rtd_s, raw_s, iclk_s;
  assign {sig_s, lock_s, prim_s, offs_s, rtd_s, raw_s, iclk_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] cap_q, ovr_q, pclk_q, eomc_q, sigd_q, div_q, cpmp_q, omux_q;
  logic [7:0] vctl_q, itvl_q, psel_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cap_q <= `CPEM_CAP_RST;
      ovr_q <= 8'h00; // see RULE13
      pclk_q <= 8'h00;
      eomc_q <= `CPEM_EOMC_RST; // see RULE19
      sigd_q <= 8'h00;
      div_q <= 8'h00;
      cpmp_q <= `CPEM_CPMP_RST;
      omux_q <= `CPEM_OMUX_RST;
      vctl_q <= `CPEM_VCTL_RST;
      itvl_q <= `CPEM_ITVL_RST;
      psel_q <= 8'h00;
    end else if (I_WR) begin
      unique case (I_ADDR)
        `CPEM_A_CAP: cap_q <= I_WDATA;
        `CPEM_A_OVR: ovr_q <= I_WDATA; // see RULE13
        `CPEM_A_PCLK: pclk_q <= I_WDATA;
        `CPEM_A_EOMC: eomc_q <= I_WDATA; // see RULE20
        `CPEM_A_SIGD: sigd_q <= I_WDATA;
        `CPEM_A_DIV: div_q <= I_WDATA;
        `CPEM_A_CPMP: cpmp_q <= I_WDATA;
        `CPEM_A_OMUX: omux_q <= I_WDATA;
        `CPEM_A_VCTL: vctl_q <= I_WDATA;
        `CPEM_A_ITVL: itvl_q <= I_WDATA;
        `CPEM_A_PSEL: psel_q <= I_WDATA;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel enable and free-run overrides
  logic sd_force, ch_en, mux_ovr, gen_en, pat_load, pat_clk_en, pat_run;
  logic [2:0] out_sel;
  assign sd_force = sigd_q[7] & ~sigd_q[6]; // see RULE7
  assign ch_en = sig_s | sd_force; // see RULE6
  assign mux_ovr = ovr_q[5];
  // Sync mode: lock follows the recovery loop, never the mux choice
  assign out_sel = mux_ovr ? omux_q[7:5] :
                   (lock_s ? 3'h1 : omux_q[7:5]); // see RULE2
  assign gen_en = omux_q[4];
  assign pat_load = psel_q[3];
  assign pat_clk_en = pclk_q[5];
  assign pat_run = gen_en & pat_load & pat_clk_en & ch_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generator
  logic [30:0] lfsr_q;
  logic p31;
  assign p31 = (psel_q[1:0] == `CPEM_PAT_P31); // see RULE4
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      lfsr_q <= 31'h7fff_ffff;
    end else if (!gen_en || !pat_load) begin
      lfsr_q <= 31'h7fff_ffff; // see RULE22
    end else if (pat_run) begin
      if (p31) begin
        lfsr_q <= {lfsr_q[29:0], lfsr_q[30] ^ lfsr_q[27]}; // see RULE1
      end else begin
        lfsr_q <= {lfsr_q[30:9], lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]}; // see RULE22
      end
    end
  end
  logic pat_bit;
  assign pat_bit = p31 ? lfsr_q[30] : lfsr_q[8];

  ////////////////////////////////////////////////////////////////////////////
  // Output drive and analog controls
  logic tx_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tx_q <= 1'b0;
    end else if (!ch_en) begin
      tx_q <= 1'b0; // see RULE6
    end else begin
      unique case (out_sel)
        `CPEM_SEL_PRBS: tx_q <= pat_run & pat_bit; // see RULE5
        `CPEM_SEL_ICLK: tx_q <= iclk_s;
        3'h1: tx_q <= rtd_s;
        3'h0: tx_q <= raw_s;
        default: tx_q <= 1'b0;
      endcase
    end
  end
  assign O_TX_BIT = tx_q;

  logic ch_en_q, cp_q, dovr_q, covr_q, vctl_en_q, free_q;
  logic [2:0] dsel_q;
  logic [4:0] capc_q, vcode_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ch_en_q <= 1'b0;
      cp_q <= 1'b1;
      dovr_q <= 1'b0;
      covr_q <= 1'b0;
      vctl_en_q <= 1'b0;
      free_q <= 1'b0;
      dsel_q <= 3'h0;
      capc_q <= 5'h00;
      vcode_q <= 5'h00;
    end else begin
      ch_en_q <= ch_en;
      cp_q <= ~(ovr_q[3] & (cpmp_q[1:0] == 2'h0)); // see RULE8
      dovr_q <= ovr_q[2]; // see RULE9
      dsel_q <= ovr_q[2] ? div_q[6:4] : 3'h0; // see RULE9
      covr_q <= ovr_q[7];
      capc_q <= ovr_q[7] ? cap_q[4:0] : 5'h00; // see RULE10
      vctl_en_q <= ovr_q[6]; // see RULE11
      vcode_q <= ovr_q[6] ? vctl_q[4:0] : 5'h00; // see RULE11
      free_q <= ovr_q[3];
    end
  end
  assign O_CH_ENABLE = ch_en_q;
  assign O_CHARGE_PUMP_EN = cp_q;
  assign O_DIV_OVR = dovr_q;
  assign O_DIV_SEL = dsel_q;
  assign O_CAP_OVR = covr_q;
  assign O_CAP_COUNT = capc_q;
  assign O_VCTL_EN = vctl_en_q;
  assign O_VCTL_CODE = vcode_q;
  assign O_PLL_FREE_RUN = free_q;

  ////////////////////////////////////////////////////////////////////////////
  // Eye monitor: periodic opening measurement
  function automatic logic [8:0] range_mv(input logic [1:0] code);
    range_mv = 9'((code + 2'h0) * 100 + 100); // see RULE21
  endfunction : range_mv

  cpem_state_t st_q;
  logic [11:0] per_q;
  logic [7:0] ivl_q;
  logic [15:0] hit_q, hitsave_q, hit_sum;
  logic [5:0] ph_q, vo_q, hlo_q, hhi_q, vlo_q, vhi_q, hlo_n, hhi_n;
  logic inh_q, inv_q;
  logic [7:0] hopn_q, vopn_q;
  logic step, hit_zero;
  assign step = (ivl_q == itvl_q);
  // Closing cycle counted too, so a one-cycle interval still sees hits
  assign hit_sum = hit_q + {15'h0000, (prim_s ^ offs_s)}; // see RULE15
  assign hit_zero = (hit_sum == 16'h0000);
  assign hlo_n = (hit_zero && !inh_q) ? ph_q : hlo_q;
  assign hhi_n = hit_zero ? ph_q : hhi_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= CPEM_IDLE;
      per_q <= 12'h000;
      ivl_q <= 8'h00;
      hit_q <= 16'h0000;
      hitsave_q <= 16'h0000;
      ph_q <= 6'h00;
      vo_q <= 6'h00;
      hlo_q <= 6'h00;
      hhi_q <= 6'h00;
      vlo_q <= 6'h00;
      vhi_q <= 6'h00;
      inh_q <= 1'b0;
      inv_q <= 1'b0;
      hopn_q <= 8'h00;
      vopn_q <= 8'h00;
    end else begin
      unique case (st_q)
        CPEM_IDLE: begin
          per_q <= (per_q == 12'(`CPEM_MEAS_CYC - 1)) ? 12'h000 : per_q + 12'h001;
          if (per_q == 12'(`CPEM_MEAS_CYC - 1) && lock_s) begin // see RULE18
            st_q <= CPEM_HSWP;
            ph_q <= 6'h00;
            vo_q <= `CPEM_MID_VOLT; // see RULE16
            ivl_q <= 8'h00;
            hit_q <= 16'h0000;
            inh_q <= 1'b0;
          end
        end
        CPEM_HSWP, CPEM_VSWP: begin
          ivl_q <= step ? 8'h00 : ivl_q + 8'h01;
          hit_q <= step ? 16'h0000 : hit_sum;
          if (step) begin
            hitsave_q <= hit_sum;
            if (st_q == CPEM_HSWP) begin
              inh_q <= inh_q | hit_zero;
              hlo_q <= hlo_n;
              hhi_q <= hhi_n;
              ph_q <= ph_q + 6'h01;
              if (ph_q == `CPEM_SWEEP_LAST) begin
                st_q <= CPEM_VSWP; // see RULE16
                // Includes this point's bounds; summed wide so it cannot wrap
                ph_q <= 6'(({1'b0, hlo_n} + {1'b0, hhi_n}) >> 1);
                vo_q <= 6'h00;
                inv_q <= 1'b0;
              end
            end else begin
              inv_q <= inv_q | hit_zero;
              vlo_q <= (hit_zero && !inv_q) ? vo_q : vlo_q;
              vhi_q <= hit_zero ? vo_q : vhi_q;
              vo_q <= vo_q + 6'h01;
              if (vo_q == `CPEM_SWEEP_LAST) st_q <= CPEM_DONE;
            end
          end
        end
        CPEM_DONE: begin
          hopn_q <= inh_q ? 8'({2'h0, hhi_q} - {2'h0, hlo_q} + 8'h01) : 8'h00; // see RULE17
          vopn_q <= inv_q ? 8'({2'h0, vhi_q} - {2'h0, vlo_q} + 8'h01) : 8'h00; // see RULE17
          st_q <= CPEM_IDLE;
        end
        default: st_q <= CPEM_IDLE;
      endcase
    end
  end

  logic pwr_q;
  logic [8:0] rng_q;
  logic [5:0] oph_q, ovo_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pwr_q <= 1'b0;
      rng_q <= 9'h064;
      oph_q <= 6'h00;
      ovo_q <= 6'h00;
    end else begin
      pwr_q <= ~eomc_q[5] | (st_q != CPEM_IDLE); // see RULE19
      rng_q <= range_mv(eomc_q[7:6]); // see RULE21
      oph_q <= ph_q;
      ovo_q <= vo_q;
    end
  end
  assign O_EOM_POWER = pwr_q;
  assign O_EOM_RANGE_MV = rng_q;
  assign O_EOM_PHASE = oph_q;
  assign O_EOM_VOLT = ovo_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic [7:0] rd_q;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_q <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        `CPEM_A_CAP: rd_q <= cap_q;
        `CPEM_A_OVR: rd_q <= ovr_q;
        `CPEM_A_PCLK: rd_q <= pclk_q;
        `CPEM_A_EOMC: rd_q <= eomc_q;
        `CPEM_A_SIGD: rd_q <= sigd_q;
        `CPEM_A_DIV: rd_q <= div_q;
        `CPEM_A_CPMP: rd_q <= cpmp_q;
        `CPEM_A_OMUX: rd_q <= omux_q;
        `CPEM_A_VCTL: rd_q <= vctl_q;
        `CPEM_A_ITVL: rd_q <= itvl_q;
        `CPEM_A_PSEL: rd_q <= psel_q;
        `CPEM_A_HITM: rd_q <= hitsave_q[15:8]; // see RULE15
        `CPEM_A_HITL: rd_q <= hitsave_q[7:0];
        `CPEM_A_HOPN: rd_q <= hopn_q; // see RULE17
        `CPEM_A_VOPN: rd_q <= vopn_q;
        `CPEM_A_STAT: rd_q <= {4'h0, ch_en, pat_run, lock_s, sig_s};
        default: rd_q <= 8'h00;
      endcase
    end else begin
      rd_q <= 8'h00;
    end
  end
  assign O_RDATA = rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ovr_zero_reset: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_WR && I_ADDR == `CPEM_A_OVR && I_WDATA == 8'h00) |=> ##1
    (cp_q && !dovr_q && !covr_q && !vctl_en_q)) else $error("overrides not cleared"); // see RULE13
  a_cp_disable: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (ovr_q[3] && cpmp_q[1:0] == 2'h0) |=> !cp_q) else $error("pump not off"); // see RULE8
  a_no_sig_mute: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!sig_s && !sd_force) |=> (!tx_q && !ch_en_q)) else $error("not muted"); // see RULE6
  a_force_enable: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (sigd_q[7:6] == 2'b10) |=> ch_en_q) else $error("force failed"); // see RULE7
  a_lfsr_nonzero: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (p31 ? lfsr_q != 31'h0000_0000 : lfsr_q[8:0] != 9'h000)) else $error("zero"); // see RULE22
  a_div_handoff: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ovr_q[2] |=> (dsel_q == $past(div_q[6:4]))) else $error("divider"); // see RULE9
  a_cap_handoff: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ovr_q[7] |=> (capc_q == $past(cap_q[4:0]))) else $error("cap"); // see RULE10
  a_vctl_handoff: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ovr_q[6] |=> (vctl_en_q && vcode_q == $past(vctl_q[4:0]))) else $error("vctl"); // see RULE11
  a_range_map: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (eomc_q[7:6] == 2'h3) |=> (rng_q == 9'd400)) else $error("range"); // see RULE21
  a_eom_power: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!eomc_q[5]) |=> pwr_q) else $error("eom power"); // see RULE19
  a_hsweep_mid: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (st_q == CPEM_HSWP) |-> (vo_q == `CPEM_MID_VOLT)) else $error("mid volt"); // see RULE16

endmodule : cpem_top

// >>> cpem_ctrl_model.sv
// Purpose: System controller model that drives the register port
// Assumes: Read data stand only in the cycle after the read strobe
// Notes: Shadows of the override and mux registers keep earlier bits set
`timescale 1ns/1ps
`include "cpem_regs.svh"
module cpem_ctrl_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  logic [7:0] ovr_q = 8'h00;
  logic [7:0] omux_q = `CPEM_OMUX_RST;
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // A released bus must not look like the last transfer
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd
  ////////////////////////////////////////////////////////////////////
  task automatic ovr_set(input logic [7:0] b);
    ovr_q = ovr_q | b;
    wr(`CPEM_A_OVR, ovr_q);
  endtask : ovr_set
  task automatic ovr_clear;
    ovr_q = 8'h00;
    wr(`CPEM_A_OVR, ovr_q);
  endtask : ovr_clear
  task automatic prbs_start(input logic [1:0] pat);
    omux_q = omux_q | 8'h10;
    wr(`CPEM_A_OMUX, omux_q);
    wr(`CPEM_A_PSEL, 8'h00);
    wr(`CPEM_A_PSEL, {6'h00, pat});
    wr(`CPEM_A_PSEL, {5'h01, 1'b0, pat});
    wr(`CPEM_A_PCLK, 8'h20);
  endtask : prbs_start
  task automatic out_sel(input logic [2:0] s);
    omux_q = {s, omux_q[4:0]};
    wr(`CPEM_A_OMUX, omux_q);
  endtask : out_sel
endmodule : cpem_ctrl_model

// >>> tb.sv
// Purpose: Self-checking bench for the pattern generator and eye monitor
// Assumes: Sync inputs settle within eight cycles
// Notes: Pattern checked by its recurrence, not by a golden stream
`timescale 1ns/1ps
`include "cpem_regs.svh"
module tb;
  logic clk, arst_n, sig, lock, pri, ofs, rtd, raw, iclk, wr, rd;
  logic tx, chen, cp, dovr, covr, ven, pfr, eomp;
  logic [7:0] addr, wdata, rdata, d, e;
  logic [2:0] dsel;
  logic [4:0] cap, vcode;
  logic [8:0] rmv;
  logic [5:0] ph, vo;
  logic q[$];
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] ra [11] = '{`CPEM_A_CAP, `CPEM_A_OVR, `CPEM_A_PCLK, `CPEM_A_EOMC,
    `CPEM_A_SIGD, `CPEM_A_DIV, `CPEM_A_CPMP, `CPEM_A_OMUX, `CPEM_A_VCTL,
    `CPEM_A_ITVL, `CPEM_A_PSEL};
  logic [7:0] rv [11] = '{8'h08, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h03,
    8'he0, 8'h12, 8'h10, 8'h00};
  cpem_ctrl_model m (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  cpem_top DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SIG_PRESENT(sig), .I_CDR_LOCKED(lock),
    .I_PRIMARY_BIT(pri), .I_OFFSET_BIT(ofs), .I_RETIMED_BIT(rtd), .I_RAW_BIT(raw),
    .I_ICLK_BIT(iclk), .O_TX_BIT(tx), .O_CH_ENABLE(chen), .O_CHARGE_PUMP_EN(cp),
    .O_DIV_SEL(dsel), .O_DIV_OVR(dovr), .O_CAP_COUNT(cap), .O_CAP_OVR(covr),
    .O_VCTL_EN(ven), .O_VCTL_CODE(vcode), .O_PLL_FREE_RUN(pfr), .O_EOM_POWER(eomp),
    .O_EOM_RANGE_MV(rmv), .O_EOM_PHASE(ph), .O_EOM_VOLT(vo));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    m.rd(a, d);
    chk($sformatf("reg %h", a), 16'(x), 16'(d));
  endtask : rchk
  // Accepts either tap orientation of the polynomial; stuck or zero fails
  task automatic prbs_chk(input int n, input int l, input int a);
    bit ok_a, ok_b, any;
    ok_a = 1;
    ok_b = 1;
    any = 0;
    q.delete();
    repeat (n) begin
      @(posedge clk);
      #1;
      q.push_back(tx);
    end
    for (int i = l; i < n; i++) begin
      if (q[i] !== (q[i-a] ^ q[i-l])) ok_a = 0;
      if (q[i] !== (q[i-l+a] ^ q[i-l])) ok_b = 0;
      any |= q[i];
    end
    chk("prbs stream", 16'h1, 16'(any & (ok_a | ok_b)));
  endtask : prbs_chk
  task automatic wait_eom;
    int k;
    k = 0;
    // Let a sweep already under way finish, so the next one is seen from its start
    while (eomp !== 1'b0 && k < 3000) begin
      idle(1);
      k++;
    end
    while (eomp !== 1'b1 && k < 3000) begin
      idle(1);
      k++;
    end
    chk("eom wake", 16'h1, 16'(eomp));
    if (eomp !== 1'b1) give_verdict();
  endtask : wait_eom
  ////////////////////////////////////////////////////////////////////
  initial begin
    arst_n <= 1'b0;
    sig <= 1'b0;
    lock <= 1'b0;
    pri <= 1'b0;
    ofs <= 1'b0;
    rtd <= 1'b0;
    raw <= 1'b0;
    iclk <= 1'b0;
    idle(3);
    chk("range rst", 16'd100, 16'(rmv));
    @(posedge clk);
    arst_n <= 1'b1;
    idle(2);
    for (int i = 0; i < 11; i++) rchk(ra[i], rv[i]);
    rchk(8'h40, 8'h00);
    chk("chan off", 16'h0, 16'(chen));
    m.wr(`CPEM_A_SIGD, 8'h80);
    idle(8);
    chk("chan on", 16'h1, 16'(chen));
    m.ovr_set(8'h08);
    m.wr(`CPEM_A_CPMP, 8'h00);
    idle(3);
    chk("pump free", 16'h1, {cp, pfr});
    m.ovr_set(8'h04);
    m.wr(`CPEM_A_DIV, 8'h30);
    idle(3);
    chk("div", 16'hb, {dovr, dsel});
    m.wr(`CPEM_A_DIV, 8'h00);
    idle(3);
    chk("div one", 16'h8, {dovr, dsel});
    m.ovr_set(8'h80);
    m.wr(`CPEM_A_CAP, 8'h08);
    m.ovr_set(8'h40);
    m.wr(`CPEM_A_VCTL, 8'h12);
    idle(3);
    chk("cap", 16'h28, {covr, cap});
    chk("vctl", 16'h32, {ven, vcode});
    rchk(`CPEM_A_OVR, 8'hcc);
    m.prbs_start(`CPEM_PAT_P9);
    m.ovr_set(8'h20);
    m.out_sel(`CPEM_SEL_PRBS);
    idle(4);
    m.rd(`CPEM_A_STAT, d);
    chk("status", 16'h3, 16'(d[3:2]));
    prbs_chk(100, 9, 5);
    m.prbs_start(`CPEM_PAT_P31);
    idle(4);
    prbs_chk(200, 31, 28);
    m.out_sel(`CPEM_SEL_ICLK);
    @(posedge clk);
    iclk <= 1'b1;
    idle(8);
    chk("iclk hi", 16'h1, 16'(tx));
    @(posedge clk);
    iclk <= 1'b0;
    idle(8);
    chk("iclk lo", 16'h0, 16'(tx));
    m.out_sel(`CPEM_SEL_PRBS);
    idle(4);
    prbs_chk(200, 31, 28);
    m.ovr_clear();
    idle(3);
    chk("normal", 16'h10, {cp, dovr, covr, ven, pfr});
    for (int c = 0; c < 4; c++) begin
      m.wr(`CPEM_A_EOMC, 8'(c * 64));
      idle(3);
      chk("eom range", 16'(100 * (c + 1)), 16'(rmv));
      chk("eom on", 16'h1, 16'(eomp));
    end
    m.wr(`CPEM_A_EOMC, 8'h20);
    idle(3);
    chk("eom off", 16'h0, 16'(eomp));
    m.wr(`CPEM_A_ITVL, 8'h00);
    @(posedge clk);
    sig <= 1'b1;
    lock <= 1'b1;
    pri <= 1'b1;
    ofs <= 1'b1;
    rtd <= 1'b1;
    idle(8);
    chk("retimed", 16'h1, 16'(tx));
    m.ovr_set(8'h20);
    m.out_sel(3'h0);
    @(posedge clk);
    raw <= 1'b1;
    idle(8);
    chk("raw", 16'h1, 16'(tx));
    chk("pump lock", 16'h1, 16'(cp));
    wait_eom();
    chk("mid volt", 16'h20, 16'(vo));
    idle(300);
    chk("centre", 16'h1f, 16'(ph));
    rchk(`CPEM_A_HOPN, 8'h40);
    rchk(`CPEM_A_VOPN, 8'h40);
    @(posedge clk);
    ofs <= 1'b0;
    idle(300);
    wait_eom();
    idle(300);
    rchk(`CPEM_A_HOPN, 8'h00);
    rchk(`CPEM_A_VOPN, 8'h00);
    m.rd(`CPEM_A_HITM, d);
    m.rd(`CPEM_A_HITL, e);
    chk("hits", 16'h1, 16'({d, e} != 16'h0000));
    give_verdict();
  end
endmodule : tb
